// *** rtl/adcrop_pkg.sv ***
// Shared constants and types for the converter result output port.
package adcrop_pkg;
   localparam int RES_W = 12;
   localparam int PAR_W = 6;
   localparam int MSB_HALF_LO = 6;
   localparam int LSB_HALF_W = 4;
   // Positions of the pin inputs in the synchroniser vector.
   localparam int PIN_CS = 0;
   localparam int PIN_RC = 1;
   localparam int PIN_HS = 2;
   localparam int PIN_FMT = 3;
   localparam int PIN_SRC = 4;
   localparam int PIN_XCK = 5;
   localparam int PIN_N = 6;
   // Internal serial bit clock timing.
   localparam int CLK_MHZ = 125;
   localparam int BIT_PERIOD_NS = 160;
   localparam int HALF_CYC = ((BIT_PERIOD_NS / 2) * CLK_MHZ + 999) / 1000;
   localparam int DIV_W = 8;
   localparam logic [3:0] FRAME_BITS = 4'hc;
   localparam logic [PIN_N-1:0] PIN_RST = 6'h01;

   typedef enum logic [1:0] {
      ADCROP_IDLE = 2'b00,
      ADCROP_CLK_LO = 2'b01,
      ADCROP_CLK_HI = 2'b11,
      ADCROP_EXT = 2'b10
   } adcrop_state_t;

   typedef struct packed {
      logic [PIN_N-1:0] sy1;
      logic [PIN_N-1:0] sy2;
      logic [PIN_N-1:0] sy3;
      logic [PIN_N-1:0] filt;
      logic conv_l;
      logic xck_l;
      logic [1:0][RES_W-1:0] buf_d;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] buf_cnt;
      logic [RES_W-1:0] hold;
      logic [RES_W-1:0] shift;
      logic [3:0] bits_left;
      logic [DIV_W-1:0] div;
      adcrop_state_t st;
      logic sclk;
      logic sdata;
      logic [PAR_W-1:0] par;
      logic par_oe_b;
      logic conv_start;
   } adcrop_regs_t;
endpackage

// *** rtl/adcrop_port.sv ***
// Result output port: parallel half-word port and serial path of a 12-bit converter.
// How it works
// - Code format select high gives straight binary, low gives two's complement.
// - Source select high: host drives bit clock, data shifts on its falling edges.
// - Source select low: each convert sends previous result with 12 own clock pulses.
// - Half select low: parallel bits five to zero carry result bits 11 to 6.
// - Half select high: parallel bits five to two carry result bits 3 to 0.
// - Half select high: parallel bits one and zero are driven low.
// - Parallel outputs float when chip select is high or read/convert is low.
// - Half select picks the six high or four low result bits.
// - Falling read/convert with chip select low starts a new conversion.
// - Internal mode emits 12 pulses per conversion, then holds bit clock low.
`timescale 1ns/1ps
`default_nettype none
module adcrop_port
   import adcrop_pkg::*;
#(
   parameter int HALF_CYCLES = HALF_CYC
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Host pins.
   input wire logic chip_sel_b,
   input wire logic read_conv,
   input wire logic half_sel,
   input wire logic code_format_select,
   input wire logic serial_clock_source_select,
   input wire logic serial_bit_clock_i,
   output logic serial_bit_clock_o,
   output logic serial_bit_clock_oe_b,
   output logic serial_data,
   output logic [PAR_W-1:0] par_out,
   output logic par_out_oe_b,
   // Conversion core.
   output logic conv_start,
   input wire logic res_valid,
   input wire logic [RES_W-1:0] res_data,
   output logic res_ready
);

   // Refuse divider settings that the half-period counter cannot hold.
   if (HALF_CYCLES < 1 || HALF_CYCLES > (1 << DIV_W))
   begin : g_half_check
      $error("HALF_CYCLES out of range");
   end

   localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(HALF_CYCLES - 1);

   function automatic logic [RES_W-1:0] code_out(input logic [RES_W-1:0] d, input logic sb);
      code_out = sb ? d : {~d[RES_W-1], d[RES_W-2:0]};
   endfunction

   function automatic logic [PAR_W-1:0] par_sel(input logic [RES_W-1:0] d, input logic hs);
      par_sel = hs ? {d[LSB_HALF_W-1:0], 2'b00} : d[RES_W-1:MSB_HALF_LO];
   endfunction

   adcrop_regs_t q, n;
   logic [PIN_N-1:0] agree;
   logic conv_lvl;
   logic conv_cmd;
   logic xck_fall;
   logic push;
   logic pop;

   always_comb
   begin
      n = q;
      agree = q.sy2 ~^ q.sy3;
      n.sy1 = {serial_bit_clock_i, serial_clock_source_select, code_format_select, half_sel, read_conv,
               chip_sel_b};
      n.sy2 = q.sy1;
      n.sy3 = q.sy2;
      n.filt = (q.filt & ~agree) | (q.sy3 & agree);
      // Chip select and read/convert are ORed; their joint fall is the convert command.
      conv_lvl = q.filt[PIN_CS] | q.filt[PIN_RC];
      conv_cmd = q.conv_l & ~conv_lvl;
      n.conv_l = conv_lvl;
      n.conv_start = conv_cmd;
      xck_fall = q.xck_l & ~q.filt[PIN_XCK];
      n.xck_l = q.filt[PIN_XCK];
      // Two-entry buffer between the core and the holding register.
      res_ready = (q.buf_cnt != 2'h2);
      push = res_valid && res_ready;
      pop = (q.buf_cnt != 2'h0) && (q.st == ADCROP_IDLE) && !conv_cmd;
      if (push)
      begin
         n.buf_d[q.wr_ptr] = res_data;
         n.wr_ptr = ~q.wr_ptr;
      end
      if (pop)
      begin
         n.hold = q.buf_d[q.rd_ptr];
         n.rd_ptr = ~q.rd_ptr;
      end
      n.buf_cnt = q.buf_cnt + {1'b0, push} - {1'b0, pop};
      // Parallel port, refreshed every cycle from the holding register.
      n.par = par_sel(code_out(q.hold, q.filt[PIN_FMT]), q.filt[PIN_HS]);
      n.par_oe_b = q.filt[PIN_CS] | ~q.filt[PIN_RC];
      case (q.st)
         ADCROP_IDLE:
         begin
            n.sclk = 1'b0;
         end
         ADCROP_CLK_LO:
         begin
            if (q.div == '0)
            begin
               n.sclk = 1'b1;
               n.div = DIV_LOAD;
               n.st = ADCROP_CLK_HI;
            end
            else
               n.div = q.div - DIV_W'(1);
         end
         ADCROP_CLK_HI:
         begin
            if (q.div == '0)
            begin
               n.sclk = 1'b0;
               n.div = DIV_LOAD;
               n.bits_left = q.bits_left - 4'h1;
               n.shift = {q.shift[RES_W-2:0], 1'b0};
               if (q.bits_left == 4'h1)
               begin
                  n.st = ADCROP_IDLE;
                  n.sdata = 1'b0;
               end
               else
               begin
                  n.sdata = q.shift[RES_W-2];
                  n.st = ADCROP_CLK_LO;
               end
            end
            else
               n.div = q.div - DIV_W'(1);
         end
         ADCROP_EXT:
         begin
            if (xck_fall)
            begin
               n.bits_left = q.bits_left - 4'h1;
               n.shift = {q.shift[RES_W-2:0], 1'b0};
               n.sdata = (q.bits_left == 4'h1) ? 1'b0 : q.shift[RES_W-2];
               if (q.bits_left == 4'h1)
                  n.st = ADCROP_IDLE;
            end
         end
         default:
         begin
            n.st = ADCROP_IDLE;
            n.sclk = 1'b0;
         end
      endcase
      // A convert command starts a frame carrying the previous result.
      if (conv_cmd)
      begin
         n.shift = code_out(q.hold, q.filt[PIN_FMT]);
         n.sdata = q.filt[PIN_FMT] ? q.hold[RES_W-1] : ~q.hold[RES_W-1];
         n.bits_left = FRAME_BITS;
         n.div = DIV_LOAD;
         n.sclk = 1'b0;
         n.st = q.filt[PIN_SRC] ? ADCROP_EXT : ADCROP_CLK_LO;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         q <= '0;
         q.sy1 <= PIN_RST;
         q.sy2 <= PIN_RST;
         q.sy3 <= PIN_RST;
         q.filt <= PIN_RST;
         q.conv_l <= 1'b1;
         q.par_oe_b <= 1'b1;
      end
      else
         q <= n;
   end

   assign serial_bit_clock_o = q.sclk;
   assign serial_bit_clock_oe_b = q.filt[PIN_SRC];
   assign serial_data = q.sdata;
   assign par_out = q.par;
   assign par_out_oe_b = q.par_oe_b;
   assign conv_start = q.conv_start;

   // Helper counting bit clock pulses within one internal frame.
   logic [4:0] pulses_r;
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         pulses_r <= '0;
      else if (conv_cmd)
         pulses_r <= '0;
      else if (q.st == ADCROP_CLK_LO && q.div == '0)
         pulses_r <= pulses_r + 5'h01;
   end

   sequence int_frame_end;
      q.st == ADCROP_CLK_HI && q.div == '0 && q.bits_left == 4'h1 && !conv_cmd;
   endsequence

   sequence int_frame_go;
      conv_cmd && !q.filt[PIN_SRC];
   endsequence

   pulse_count_a: assert property (@(posedge clock) disable iff (!rst_b)
      int_frame_end |=> pulses_r == 5'h0c && q.st == ADCROP_IDLE) else $error("frame pulse count wrong");
   clk_idle_low_a: assert property (@(posedge clock) disable iff (!rst_b)
      int_frame_end |=> !serial_bit_clock_o [*2]) else $error("bit clock not low after frame");
   frame_start_a: assert property (@(posedge clock) disable iff (!rst_b)
      int_frame_go |=> !serial_bit_clock_oe_b && q.st == ADCROP_CLK_LO ##[1:300] serial_bit_clock_o)
      else $error("internal frame did not start");
   ext_clock_a: assert property (@(posedge clock) disable iff (!rst_b)
      conv_cmd && q.filt[PIN_SRC] |=> serial_bit_clock_oe_b && q.st == ADCROP_EXT && !serial_bit_clock_o)
      else $error("bit clock driven in ext mode");
   conv_start_a: assert property (@(posedge clock) disable iff (!rst_b)
      $fell(conv_lvl) |=> conv_start ##1 !conv_start) else $error("convert command not passed on");
   par_float_a: assert property (@(posedge clock) disable iff (!rst_b)
      (q.filt[PIN_CS] || !q.filt[PIN_RC]) |=> par_out_oe_b) else $error("parallel port driven while deselected");
   msb_half_a: assert property (@(posedge clock) disable iff (!rst_b)
      !q.filt[PIN_HS] && q.filt[PIN_FMT] |=> par_out == $past(q.hold[RES_W-1:MSB_HALF_LO]))
      else $error("high half wrong");
   lsb_half_a: assert property (@(posedge clock) disable iff (!rst_b)
      q.filt[PIN_HS] |=> par_out[PAR_W-1:2] == $past(q.hold[LSB_HALF_W-1:0]) && par_out[1:0] == 2'b00)
      else $error("low half wrong");
   twos_msb_a: assert property (@(posedge clock) disable iff (!rst_b)
      !q.filt[PIN_HS] && !q.filt[PIN_FMT] |=> par_out[PAR_W-1] == !$past(q.hold[RES_W-1]))
      else $error("two's complement sign wrong");
   hold_stable_a: assert property (@(posedge clock) disable iff (!rst_b)
      q.st != ADCROP_IDLE |=> $stable(q.hold)) else $error("result changed mid frame");

endmodule // adcrop_port
`default_nettype wire

// *** verif/adcrop_host.sv ***
// Host model: drives the bit clock in external mode and captures serial words.
`timescale 1ns/1ps
`default_nettype none
module adcrop_host
   import adcrop_pkg::*;
(
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_b,
   // Control.
   input wire logic go,
   input wire logic conv_start,
   // Pins.
   input wire logic sclk_o,
   input wire logic sclk_oe_b,
   input wire logic sdata,
   output logic sclk_pin,
   output logic [RES_W-1:0] cap,
   output logic [4:0] nbits
);
   logic sclk_h;
   logic pin_r;
   logic [4:0] cnt_r;
   logic [4:0] left_r;
   assign sclk_pin = sclk_oe_b ? sclk_h : sclk_o;
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {sclk_h, pin_r, cnt_r, left_r, cap, nbits} <= '0;
      end
      else
      begin
         pin_r <= sclk_pin;
         cnt_r <= cnt_r + 5'h01;
         if (go)
         begin
            left_r <= 5'h18;
            cnt_r <= 5'h00;
         end
         else if (left_r != 5'h00 && cnt_r == 5'h0b)
         begin
            sclk_h <= ~sclk_h;
            left_r <= left_r - 5'h01;
            cnt_r <= 5'h00;
         end
         if (conv_start)
            nbits <= 5'h00;
         else if (sclk_pin && !pin_r)
         begin
            cap <= {cap[RES_W-2:0], sdata};
            nbits <= nbits + 5'h01;
         end
      end
   end
endmodule // adcrop_host
`default_nettype wire

// *** verif/tb_top.sv ***
// Testbench for the converter result output port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top
   import adcrop_pkg::*;
;
   logic clock = 1'b0, rst_b = 1'b0, chip_sel_b = 1'b0, read_conv = 1'b1, half_sel = 1'b0;
   logic fmt = 1'b1, src = 1'b0, res_valid = 1'b0, go = 1'b0;
   logic [RES_W-1:0] res_data = '0, cap;
   logic sclk_o, sclk_oe_b, sdata, conv_start, res_ready, pin, par_oe_b;
   logic [PAR_W-1:0] par_out;
   logic [4:0] nbits;
   int check_count = 0, n_fail = 0, n_conv = 0;
   initial
   begin
      forever #4 clock = ~clock;
   end
   adcrop_port #(.HALF_CYCLES(2)) u_dut (.clock(clock), .rst_b(rst_b), .chip_sel_b(chip_sel_b),
      .read_conv(read_conv), .half_sel(half_sel), .code_format_select(fmt), .serial_clock_source_select(src),
      .serial_bit_clock_i(pin), .serial_bit_clock_o(sclk_o), .serial_bit_clock_oe_b(sclk_oe_b),
      .serial_data(sdata), .par_out(par_out), .par_out_oe_b(par_oe_b), .conv_start(conv_start),
      .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
   adcrop_host u_host (.clock(clock), .rst_b(rst_b), .go(go), .conv_start(conv_start), .sclk_o(sclk_o),
      .sclk_oe_b(sclk_oe_b), .sdata(sdata), .sclk_pin(pin), .cap(cap), .nbits(nbits));
   always @(posedge clock)
      if (conv_start === 1'b1)
         n_conv++;
   function automatic logic [RES_W-1:0] coded(input logic [RES_W-1:0] w, input logic f);
      return f ? w : w ^ 12'h800;
   endfunction
   task automatic close_out();
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic settle();
      repeat (8) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic push(input logic [RES_W-1:0] w);
      int i;
      @(posedge clock);
      res_valid <= 1'b1;
      res_data <= w;
      for (i = 0; i < 500; i++)
      begin
         @(negedge clock);
         if (res_ready === 1'b1)
            break;
      end
      @(posedge clock);
      res_valid <= 1'b0;
      if (i == 500)
      begin
         n_fail++;
         close_out();
      end
   endtask
   task automatic par_chk(input logic hs, input logic [RES_W-1:0] w);
      logic [RES_W-1:0] c;
      @(posedge clock);
      half_sel <= hs;
      settle();
      c = coded(w, fmt);
      `CHK(par_out_oe_b_w(), 1'b0)
      `CHK(par_out, hs ? {c[3:0], 2'b00} : c[11:6])
      @(posedge clock);
   endtask
   function automatic logic par_out_oe_b_w();
      return par_oe_b;
   endfunction
   task automatic convert(input int inc);
      int n0;
      n0 = n_conv;
      @(posedge clock);
      read_conv <= 1'b0;
      settle();
      `CHK(par_oe_b, 1'b1)
      @(posedge clock);
      read_conv <= 1'b1;
      `CHK(n_conv - n0, inc)
   endtask
   task automatic wait_bits();
      int i;
      for (i = 0; i < 2000 && nbits !== 5'h0c; i++)
         @(posedge clock);
      if (i == 2000)
      begin
         n_fail++;
         close_out();
      end
   endtask
   initial
   begin
      repeat (3) @(negedge clock);
      rst_b <= 1'b1;
      push(12'ha5c);
      settle();
      par_chk(1'b0, 12'ha5c);
      par_chk(1'b1, 12'ha5c);
      fmt <= 1'b0;
      par_chk(1'b0, 12'ha5c);
      chip_sel_b <= 1'b1;
      settle();
      `CHK(par_oe_b, 1'b1)
      convert(0);
      chip_sel_b <= 1'b0;
      settle();
      convert(1);
      wait_bits();
      settle();
      `CHK(cap, coded(12'ha5c, 1'b0))
      `CHK(sclk_o, 1'b0)
      `CHK(nbits, 5'h0c)
      `CHK(sclk_oe_b, 1'b0)
      convert(1);
      push(12'h3c1);
      push(12'h05a);
      @(negedge clock);
      `CHK(res_ready, 1'b0)
      wait_bits();
      `CHK(cap, coded(12'ha5c, 1'b0))
      settle();
      par_chk(1'b0, 12'h05a);
      par_chk(1'b1, 12'h05a);
      src <= 1'b1;
      fmt <= 1'b1;
      settle();
      convert(1);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      wait_bits();
      `CHK(cap, 12'h05a)
      `CHK(sclk_oe_b, 1'b1)
      close_out();
   end
endmodule // tb_top
`default_nettype wire
